// ===== hdl/pmb_bridge.sv
// Device end: management slave bridged to an internal register master.
`timescale 1ns/100ps
`default_nettype none
module pmb_bridge
  import pmb_pkg::*;
#(
  parameter int LANES = PMB_LANES,
  parameter pmb_variant_e VARIANT = PMB_VAR_DUPLEX,
  parameter int RIN_W = (VARIANT == PMB_VAR_SINK) ?
    PMB_RCFG_IN_SINK : PMB_RCFG_IN_FULL,
  parameter int ROUT_W = (VARIANT == PMB_VAR_SINK) ?
    PMB_RCFG_OUT_SINK : PMB_RCFG_OUT_FULL
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic mgmt_rst,
  pmb_if.dev mgmt,
  output logic [8:0] csr_addr,
  output logic [31:0] csr_wdata,
  output logic csr_write,
  output logic csr_read,
  input wire logic [31:0] csr_rdata,
  input wire logic csr_stall,
  input wire logic reconfig_busy,
  output logic retune_start,
  output logic [RIN_W*LANES-1:0] retune_bus_out,
  input wire logic [ROUT_W*LANES-1:0] retune_bus_in,
  input wire logic [RIN_W*LANES-1:0] retune_word,
  input wire logic retune_req,
  output logic [ROUT_W*LANES-1:0] retune_status,
  output logic [LANES-1:0] tx_serial,
  input wire logic [LANES-1:0] rx_serial,
  input wire logic [LANES-1:0] tx_bits,
  output logic [LANES-1:0] rx_bits
);
  pmb_state_e st_r;
  logic [31:0] rd_r;
  logic stall_r;
  logic rcfg_pend_r;
  logic [RIN_W*LANES-1:0] rcfg_word_r;
  logic rcfg_go;
  logic req;
  logic kill;

  // A forwarded command ends on the first edge at which the core stops
  // stalling; state, strobes, read word and host stall all follow it.
  function automatic logic ends_fwd(pmb_state_e st, logic core_stall);
    return (st == PMB_FWD) && !core_stall;
  endfunction : ends_fwd

  function automatic logic takes_req(pmb_state_e st, logic any_req);
    return (st == PMB_IDLE) && any_req;
  endfunction : takes_req

  // Global reset is level sensitive and clears the same registers as the
  // pin reset on every edge while it stays high.
  assign kill = mgmt_rst;
  assign req = mgmt.mgmt_write | mgmt.mgmt_read;

  // A DONE cycle lets the host drop its strobes before the next take.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_r <= PMB_IDLE;
    end else if (kill) begin
      st_r <= PMB_IDLE;
    end else begin
      unique case (st_r)
        PMB_IDLE: begin
          if (takes_req(st_r, req)) begin
            st_r <= PMB_FWD;
          end
        end
        PMB_FWD: begin
          if (ends_fwd(st_r, csr_stall)) begin
            st_r <= PMB_DONE;
          end
        end
        PMB_DONE: begin
          st_r <= PMB_IDLE;
        end
      endcase
    end
  end

  // Master side: the accepted address and word go out unchanged, so one
  // address space behind the port covers every register.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      csr_addr <= PMB_ADDR_RST;
      csr_wdata <= PMB_RD_RST;
    end else if (kill) begin
      csr_addr <= PMB_ADDR_RST;
      csr_wdata <= PMB_RD_RST;
    end else if (takes_req(st_r, req)) begin
      csr_addr <= mgmt.mgmt_addr;
      csr_wdata <= mgmt.mgmt_write_word;
    end
  end

  // Master strobes drive the coding, reset and loopback controls behind
  // the port; write wins if a faulty host raises both.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      csr_write <= 1'b0;
      csr_read <= 1'b0;
    end else if (kill) begin
      csr_write <= 1'b0;
      csr_read <= 1'b0;
    end else if (takes_req(st_r, req)) begin
      csr_write <= mgmt.mgmt_write;
      csr_read <= mgmt.mgmt_read & ~mgmt.mgmt_write;
    end else if (ends_fwd(st_r, csr_stall)) begin
      csr_write <= 1'b0;
      csr_read <= 1'b0;
    end
  end

  // The read word stands from the completing cycle until the next read.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rd_r <= PMB_RD_RST;
    end else if (kill) begin
      rd_r <= PMB_RD_RST;
    end else if (ends_fwd(st_r, csr_stall) && csr_read) begin
      rd_r <= csr_rdata;
    end
  end

  // Stall stays high until the answer is ready; it drops for exactly the
  // completing cycle, so the host's held request ends there.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stall_r <= 1'b1;
    end else if (kill) begin
      stall_r <= 1'b1;
    end else begin
      stall_r <= !ends_fwd(st_r, csr_stall);
    end
  end

  assign mgmt.mgmt_stall = stall_r;
  assign mgmt.mgmt_read_word = rd_r;

  // Busy belongs to the management clock domain, so it is read directly:
  // a synchroniser would let a start slip out while busy is already high.
  // The cycle after a start is blocked too, since the controller can only
  // raise busy once it has seen the start.
  assign rcfg_go = rcfg_pend_r && !reconfig_busy && !retune_start &&
    !retune_req;

  // The word arrives with the one-cycle request and is held until used.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rcfg_pend_r <= 1'b0;
      rcfg_word_r <= '0;
    end else if (kill) begin
      rcfg_pend_r <= 1'b0;
      rcfg_word_r <= '0;
    end else if (retune_req) begin
      rcfg_pend_r <= 1'b1;
      rcfg_word_r <= retune_word;
    end else if (rcfg_go) begin
      rcfg_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      retune_start <= 1'b0;
      retune_bus_out <= '0;
    end else if (kill) begin
      retune_start <= 1'b0;
      retune_bus_out <= '0;
    end else begin
      retune_start <= rcfg_go;
      if (rcfg_go) begin
        retune_bus_out <= rcfg_word_r;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      retune_status <= '0;
    end else if (kill) begin
      retune_status <= '0;
    end else begin
      retune_status <= retune_bus_in;
    end
  end

  // Serial lanes: a receive pin is untimed to this clock and passes two
  // flops per lane; transmit is registered and parked low in reset.
  for (genvar ln = 0; ln < LANES; ln++) begin : g_lane
    logic rx_s1_r;
    logic rx_s2_r;
    logic tx_r;
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        rx_s1_r <= 1'b0;
        rx_s2_r <= 1'b0;
        tx_r <= 1'b0;
      end else if (kill) begin
        rx_s1_r <= 1'b0;
        rx_s2_r <= 1'b0;
        tx_r <= 1'b0;
      end else begin
        rx_s1_r <= rx_serial[ln];
        rx_s2_r <= rx_s1_r;
        tx_r <= tx_bits[ln];
      end
    end
    assign rx_bits[ln] = rx_s2_r;
    assign tx_serial[ln] = tx_r;
  end
endmodule : pmb_bridge
`default_nettype wire

// ===== inc/pmb_pkg.sv
// Shared constants and types for the management bridge.
package pmb_pkg;
  localparam int PMB_ADDR_W = 9;
  localparam int PMB_DATA_W = 32;
  localparam int PMB_LANES = 4;
  localparam int PMB_RCFG_IN_FULL = 140;
  localparam int PMB_RCFG_IN_SINK = 70;
  localparam int PMB_RCFG_OUT_FULL = 92;
  localparam int PMB_RCFG_OUT_SINK = 46;
  localparam logic [31:0] PMB_RD_RST = 32'h0000_0000;
  localparam logic [8:0] PMB_ADDR_RST = 9'h000;
  localparam logic [3:0] PMB_RCFG_LAT = 4'h2;
  localparam logic [3:0] PMB_CNT_ZERO = 4'h0;
  typedef enum logic [1:0] {PMB_VAR_SOURCE, PMB_VAR_SINK, PMB_VAR_DUPLEX}
    pmb_variant_e;
  typedef enum {PMB_IDLE, PMB_FWD, PMB_DONE} pmb_state_e;
endpackage : pmb_pkg

// ===== inc/pmb_if.sv
// Management port carrier joining host and bridge.
`timescale 1ns/100ps
`default_nettype none
interface pmb_if;
  logic [8:0] mgmt_addr;
  logic [31:0] mgmt_write_word;
  logic [31:0] mgmt_read_word;
  logic mgmt_write;
  logic mgmt_read;
  logic mgmt_stall;
  modport dev (input mgmt_addr, input mgmt_write_word, input mgmt_write,
    input mgmt_read, output mgmt_read_word, output mgmt_stall);
  modport host (output mgmt_addr, output mgmt_write_word,
    output mgmt_write, output mgmt_read, input mgmt_read_word,
    input mgmt_stall);
endinterface : pmb_if
`default_nettype wire

// ===== hdl/pmb_host.sv
// Host end: issues single register reads and writes over the port.
`timescale 1ns/100ps
`default_nettype none
module pmb_host
  import pmb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  pmb_if.host mgmt,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [8:0] cmd_addr,
  input wire logic [31:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [31:0] rsp_rdata
);
  logic active_r;
  logic [8:0] addr_r;
  logic [31:0] wd_r;
  logic wr_r;
  logic rd_r;

  // Request is held steady while the device stalls.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      active_r <= 1'b0;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      addr_r <= PMB_ADDR_RST;
      wd_r <= PMB_RD_RST;
    end else if (!active_r) begin
      if (cmd_valid) begin
        active_r <= 1'b1;
        addr_r <= cmd_addr;
        wd_r <= cmd_wdata;
        wr_r <= cmd_write;
        rd_r <= ~cmd_write;
      end
    end else if (!mgmt.mgmt_stall) begin
      active_r <= 1'b0;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= PMB_RD_RST;
    end else begin
      rsp_valid <= active_r & ~mgmt.mgmt_stall;
      if (active_r && !mgmt.mgmt_stall && rd_r) begin
        rsp_rdata <= mgmt.mgmt_read_word;
      end
    end
  end

  assign cmd_ready = ~active_r;
  assign mgmt.mgmt_addr = addr_r;
  assign mgmt.mgmt_write_word = wd_r;
  assign mgmt.mgmt_write = wr_r;
  assign mgmt.mgmt_read = rd_r;
endmodule : pmb_host
`default_nettype wire

// ===== dv/pmb_port_chk_sva.sv
// Assertions on the management port between host and bridge.
`timescale 1ns/100ps
`default_nettype none
module pmb_port_chk (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic mgmt_rst,
  input wire logic [8:0] mgmt_addr,
  input wire logic [31:0] mgmt_write_word,
  input wire logic [31:0] mgmt_read_word,
  input wire logic mgmt_write,
  input wire logic mgmt_read,
  input wire logic mgmt_stall
);
  logic req;
  assign req = mgmt_write || mgmt_read;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn || mgmt_rst);
  idle_stall_a: assert property (!req |-> mgmt_stall)
    else $error("stall low with no request");
  stall_pulse_a: assert property (!mgmt_stall |=> mgmt_stall)
    else $error("stall low for more than one cycle");
  answer_wait_a: assert property
    ($rose(req) |-> mgmt_stall [*2] ##[0:40] !mgmt_stall)
    else $error("request answered too early or never");
  req_hold_a: assert property
    (req && mgmt_stall |=> $stable({mgmt_addr, mgmt_write, mgmt_read}))
    else $error("request changed while stalled");
  wdata_hold_a: assert property
    (mgmt_write && mgmt_stall |=> $stable(mgmt_write_word))
    else $error("write word changed while stalled");
  drop_after_a: assert property (req && !mgmt_stall |=> !req)
    else $error("strobe kept after completion");
  one_kind_a: assert property (!(mgmt_write && mgmt_read))
    else $error("read and write strobes together");
  rdata_hold_a: assert property
    ($changed(mgmt_read_word) |-> mgmt_read && !mgmt_stall)
    else $error("read word changed outside a read");
  cover property (mgmt_write && !mgmt_stall);
  cover property (mgmt_read && !mgmt_stall);
  cover property (req && mgmt_stall [*6]);
endmodule : pmb_port_chk
`default_nettype wire

// ===== dv/phy_mgmt_csr_bridge_tb.sv
// Self-checking bench joining the host and bridge ends.
`timescale 1ns/100ps
`default_nettype none
module phy_mgmt_csr_bridge_tb;
  import pmb_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic mgmt_rst = 1'b0;
  logic cmd_valid = 1'b0, cmd_write = 1'b0;
  logic [8:0] cmd_addr = 9'h000;
  logic [31:0] cmd_wdata = 32'h0, rsp_rdata, csr_wdata, csr_rdata, q;
  logic cmd_ready, rsp_valid, csr_write, csr_read, csr_stall;
  logic [8:0] csr_addr;
  logic [3:0] tx_bits = 4'h0, rx_serial = 4'h0, tx_serial, rx_bits;
  logic busy = 1'b0, rq = 1'b0, rstart;
  logic [PMB_RCFG_IN_FULL*PMB_LANES-1:0] rword = '0, rout;
  logic [PMB_RCFG_OUT_FULL*PMB_LANES-1:0] rin = '0, rstat;
  int n_start = 0;
  logic [31:0] mem [512];
  logic [8:0] adr [3] = '{9'h000, 9'h1FF, 9'h0AA};
  int slow = 0, wait_n = 0, err_count = 0, n_compared = 0;
  always #5 clk_sys = ~clk_sys;
  pmb_if mgmt ();
  pmb_host i_pmb_host (.clk_sys(clk_sys), .rstn(rstn), .mgmt(mgmt),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata));
  pmb_bridge i_pmb_bridge (.clk_sys(clk_sys), .rstn(rstn),
    .mgmt_rst(mgmt_rst), .mgmt(mgmt), .csr_addr(csr_addr),
    .csr_wdata(csr_wdata), .csr_write(csr_write), .csr_read(csr_read),
    .csr_rdata(csr_rdata), .csr_stall(csr_stall), .reconfig_busy(busy),
    .retune_start(rstart), .retune_bus_out(rout), .retune_bus_in(rin),
    .retune_word(rword), .retune_req(rq), .retune_status(rstat),
    .tx_serial(tx_serial), .rx_serial(rx_serial), .tx_bits(tx_bits),
    .rx_bits(rx_bits));
  pmb_port_chk i_pmb_port_chk (.clk_sys(clk_sys), .rstn(rstn),
    .mgmt_rst(mgmt_rst), .mgmt_addr(mgmt.mgmt_addr),
    .mgmt_write_word(mgmt.mgmt_write_word),
    .mgmt_read_word(mgmt.mgmt_read_word), .mgmt_write(mgmt.mgmt_write),
    .mgmt_read(mgmt.mgmt_read), .mgmt_stall(mgmt.mgmt_stall));
  // Register core stand-in; a slow setting makes it stall each command.
  assign csr_stall = (csr_write || csr_read) && wait_n < slow;
  assign csr_rdata = csr_read ? mem[csr_addr] : 32'hA5A5_5A5A;
  always @(posedge clk_sys) begin
    wait_n <= (csr_write || csr_read) && csr_stall ? wait_n + 1 : 0;
    if (csr_write && !csr_stall) mem[csr_addr] <= csr_wdata;
  end
  // Counts reconfiguration start pulses as the bridge issues them.
  always @(posedge clk_sys) if (rstart) n_start <= n_start + 1;
  function automatic logic [31:0] dat(int i, int s);
    return {23'h0, adr[i]} ^ 32'hC3A5_0F00 ^ s;
  endfunction : dat
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task chk_bus(input logic [PMB_RCFG_IN_FULL*PMB_LANES-1:0] got,
    input logic [PMB_RCFG_IN_FULL*PMB_LANES-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bus
  task xfer(input logic w, input logic [8:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(negedge clk_sys);
    while (cmd_ready !== 1'b1 && n++ < 50) @(negedge clk_sys);
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    while (rsp_valid !== 1'b1 && n++ < 100) @(negedge clk_sys);
    q = rsp_rdata;
    chk({31'h0, rsp_valid}, 32'h1);
    @(posedge clk_sys);
  endtask : xfer
  task results;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  initial begin
    #20000;
    err_count++;
    results;
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(negedge clk_sys);
    chk({31'h0, mgmt.mgmt_stall}, 32'h1);
    chk(mgmt.mgmt_read_word, PMB_RD_RST);
    $display("reset test done");
    for (int s = 0; s < 6; s += 5) begin
      slow = s;
      @(posedge clk_sys);
      for (int i = 0; i < 3; i++) xfer(1'b1, adr[i], dat(i, s));
      for (int i = 0; i < 3; i++) begin
        chk(mem[adr[i]], dat(i, s));
        xfer(1'b0, adr[i], 32'h0);
        chk(q, dat(i, s));
      end
      $display("access test done, core delay %0d", s);
    end
    mgmt_rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk({31'h0, mgmt.mgmt_stall}, 32'h1);
    chk(mgmt.mgmt_read_word, PMB_RD_RST);
    @(posedge clk_sys);
    mgmt_rst <= 1'b0;
    @(posedge clk_sys);
    xfer(1'b0, adr[1], 32'h0);
    chk(q, dat(1, 5));
    $display("level reset test done");
    busy <= 1'b1;
    rq <= 1'b1;
    rword <= {35{16'h3C5A}};
    rin <= {23{16'hA5C3}};
    @(posedge clk_sys);
    rq <= 1'b0;
    rword <= '0;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(n_start, 32'h0);
    chk_bus(rout, '0);
    chk_bus({192'h0, rstat}, {192'h0, {23{16'hA5C3}}});
    @(posedge clk_sys);
    busy <= 1'b0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(n_start, 32'h1);
    chk_bus(rout, {35{16'h3C5A}});
    $display("retune test done");
    @(posedge clk_sys);
    tx_bits <= 4'hA;
    rx_serial <= 4'h5;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk({28'h0, tx_serial}, 32'hA);
    chk({28'h0, rx_bits}, 32'h5);
    $display("serial test done");
    results;
  end
endmodule : phy_mgmt_csr_bridge_tb
`default_nettype wire
